// [rtl/scrub_spare_consts.vh]
/*
 * constants for the scrub and spare status register bank: offsets,
 * field positions, reset values and configuration address width.
 * assumes it is included by bare name from the status register bank design file.
 */
`ifndef SCRUB_SPARE_CONSTS_VH
`define SCRUB_SPARE_CONSTS_VH

// ============================================================
// register offsets (byte addresses in configuration space)
`define CFG_ADDR_W           12
`define OFS_SPARE_SCRUB_STAT 12'h094
`define OFS_SCRUB_ADDR_LOW   12'h900
`define OFS_SCRUB_ADDR_HIGH  12'h910

// ============================================================
// spare_scrub_status fields
`define BIT_SPARE_ACTIVE     0
`define BIT_SPARE_DONE       1
`define BIT_PATROL_DONE      2

// ============================================================
// scrub_address_high fields
`define POS_CHAN_LO          16
`define POS_CHAN_HI          17
`define POS_RANK_LO          12
`define POS_RANK_HI          15
`define BIT_MIRR_PRI         11
`define POS_OFS_HI_LO        0
`define POS_OFS_HI_HI        8

// ============================================================
// reset values
`define RST_RANK_OFFSET      32'h00000000
`define RST_CHAN             2'h0
`define RST_RANK             4'h0
`define RST_MIRR_PRI         1'h1
`define RST_OFS_HI           9'h000
`define RST_WORD             32'h00000000

`endif

// [rtl/scrub_spare_status_regs.v]
/*
 * status and address register bank of the patrol scrub and rank
 * spare-copy engines, reached by word-wide configuration accesses.
 * assumes the scrub, self-test and copy engines run on mclk and give
 * single-cycle event pulses; the kick set strobe comes from the
 * neighbouring scrub control register.
 */
// Notes on behaviour
// - set pass-done flag at end of patrol pass
// - pass-done flag cleared only by writing one
// - clearing pass-done leaves patrol engine untouched
// - set copy-done flag when spare copy completes
// - new spare enable clears copy-done flag
// - update interleave target before releasing home block
// - set copy-active flag when copy starts
// - clear copy-active on completion or failure
// - low address holds last issued rank offset
// - self-test errors capture failing address
// - kick scrubs the software-written address, channel and rank zeroed in system mode, mirror bit in legacy
// - channel field: last issued, writable, legacy only
// - rank field: last issued, writable, legacy only
// - mirror-primary bit resets one, system mode only
// - upper offset field: last issued and writable
// - kick bit self-clears once scrub issued
`timescale 1ns/1ps
`default_nettype none
`include "scrub_spare_consts.vh"

module scrub_spare_status_regs #(
	parameter RANK_W = 3
) (
	// clock and reset
	input  wire                   mclk,
	input  wire                   rst_n,
	// configuration access
	input  wire [`CFG_ADDR_W-1:0] cfg_addr,
	input  wire                   cfg_wr,
	input  wire                   cfg_rd,
	input  wire [31:0]            cfg_wdata,
	output reg  [31:0]            cfg_rdata,
	output reg                    cfg_rack,
	// patrol mode
	input  wire                   system_addr_mode,
	// patrol engine events
	input  wire                   patrol_pass_end,
	input  wire                   scrub_issued,
	input  wire [31:0]            issued_rank_offset,
	input  wire [1:0]             issued_chan,
	input  wire [3:0]             issued_rank,
	input  wire                   issued_mirr_pri,
	input  wire [8:0]             issued_offset_hi,
	// memory self test
	input  wire                   selftest_active,
	input  wire                   selftest_error,
	input  wire [31:0]            fail_rank_offset,
	input  wire [1:0]             fail_chan,
	input  wire [3:0]             fail_rank,
	input  wire                   fail_mirr_pri,
	input  wire [8:0]             fail_offset_hi,
	// scrub kick
	input  wire                   scrub_kick_set,
	output reg                    scrub_kick,
	output reg  [31:0]            kick_rank_offset,
	output reg  [1:0]             kick_chan,
	output reg  [3:0]             kick_rank,
	output reg                    kick_mirr_pri,
	output reg  [8:0]             kick_offset_hi,
	// spare copy engine
	input  wire                   spare_enable_new,
	input  wire                   spare_start,
	input  wire                   spare_finish,
	input  wire                   spare_fail,
	input  wire [RANK_W-1:0]      dst_rank,
	output wire                   rank_interleave_target_we,
	output wire [RANK_W-1:0]      rank_interleave_target_rank,
	output wire                   request_home_release
);

	// ============================================================
	// address decode
	wire hit_stat = (cfg_addr == `OFS_SPARE_SCRUB_STAT); // status word
	wire hit_low  = (cfg_addr == `OFS_SCRUB_ADDR_LOW);   // low address
	wire hit_high = (cfg_addr == `OFS_SCRUB_ADDR_HIGH);  // high address
	wire wr_stat  = cfg_wr & hit_stat;                   // status write
	wire wr_low   = cfg_wr & hit_low;                    // low write
	wire wr_high  = cfg_wr & hit_high;                   // high write

	// ============================================================
	// stored state
	reg        patrol_done;  // patrol pass complete, write one clear
	reg [31:0] rank_offset;  // low scrub address
	reg [1:0]  chan;         // channel of last or next scrub
	reg [3:0]  rank;         // physical rank of last or next scrub
	reg        mirr_pri;     // primary copy indicator
	reg [8:0]  offset_hi;    // upper rank offset bits

	wire spare_active;       // copy in progress, from tracker
	wire spare_done;         // copy complete, from tracker

	// legacy mode is the complement of system-address mode
	wire legacy_mode = ~system_addr_mode;

	// capture: a self-test error wins over a patrol issue, as the
	// engines are not expected to run together
	wire cap_fail  = selftest_active & selftest_error;
	wire cap_issue = scrub_issued & ~cap_fail;

	// ============================================================
	// patrol pass flag
	// set wins over a same-cycle write-one clear so no pass is lost;
	// this flag feeds nothing back to the patrol engine
	always @(posedge mclk) begin
		if (!rst_n) begin
			patrol_done <= 1'b0;
		end else if (patrol_pass_end) begin
			patrol_done <= 1'b1;
		end else if (wr_stat && cfg_wdata[`BIT_PATROL_DONE]) begin
			patrol_done <= 1'b0;
		end
	end

	// ============================================================
	// low scrub address
	// hardware capture beats a software write; software is meant to
	// stop patrol first, so a collision is its own fault
	always @(posedge mclk) begin
		if (!rst_n) begin
			rank_offset <= `RST_RANK_OFFSET;
		end else if (cap_fail) begin
			rank_offset <= fail_rank_offset;
		end else if (cap_issue) begin
			rank_offset <= issued_rank_offset;
		end else if (wr_low) begin
			rank_offset <= cfg_wdata;
		end
	end

	// ============================================================
	// high scrub address fields
	// channel and rank track issues only in legacy mode, mirror bit
	// only in system-address mode; the upper offset always tracks
	always @(posedge mclk) begin
		if (!rst_n) begin
			chan      <= `RST_CHAN;
			rank      <= `RST_RANK;
			mirr_pri  <= `RST_MIRR_PRI;
			offset_hi <= `RST_OFS_HI;
		end else if (cap_fail) begin
			chan      <= fail_chan;
			rank      <= fail_rank;
			mirr_pri  <= fail_mirr_pri;
			offset_hi <= fail_offset_hi;
		end else if (cap_issue) begin
			if (legacy_mode) begin
				chan <= issued_chan;
				rank <= issued_rank;
			end else begin
				mirr_pri <= issued_mirr_pri;
			end
			offset_hi <= issued_offset_hi;
		end else if (wr_high) begin
			chan      <= cfg_wdata[`POS_CHAN_HI:`POS_CHAN_LO];
			rank      <= cfg_wdata[`POS_RANK_HI:`POS_RANK_LO];
			mirr_pri  <= cfg_wdata[`BIT_MIRR_PRI];
			offset_hi <= cfg_wdata[`POS_OFS_HI_HI:`POS_OFS_HI_LO];
		end
	end

	// ============================================================
	// scrub kick
	// the kick address is latched at the set strobe so the engine
	// scrubs exactly what software wrote even if a capture follows;
	// a set arriving with the issue pulse is kept, set wins
	always @(posedge mclk) begin
		if (!rst_n) begin
			scrub_kick       <= 1'b0;
			kick_rank_offset <= `RST_RANK_OFFSET;
			kick_chan        <= `RST_CHAN;
			kick_rank        <= `RST_RANK;
			kick_mirr_pri    <= 1'b0;
			kick_offset_hi   <= `RST_OFS_HI;
		end else if (scrub_kick_set) begin
			scrub_kick       <= 1'b1;
			kick_rank_offset <= rank_offset;
			// fields outside the active mode are presented as zero
			kick_chan        <= legacy_mode ? chan : `RST_CHAN;
			kick_rank        <= legacy_mode ? rank : `RST_RANK;
			kick_mirr_pri    <= legacy_mode ? 1'b0 : mirr_pri;
			kick_offset_hi   <= offset_hi;
		end else if (scrub_kick && scrub_issued) begin
			scrub_kick <= 1'b0;
		end
	end

	// ============================================================
	// read data, one cycle after the read strobe
	// unmapped offsets and unlisted bits return zero
	reg [31:0] next_rdata; // read word before registering

	always @* begin
		next_rdata = `RST_WORD;
		if (hit_stat) begin
			next_rdata[`BIT_SPARE_ACTIVE] = spare_active;
			next_rdata[`BIT_SPARE_DONE]   = spare_done;
			next_rdata[`BIT_PATROL_DONE]  = patrol_done;
		end else if (hit_low) begin
			next_rdata = rank_offset;
		end else if (hit_high) begin
			next_rdata[`POS_CHAN_HI:`POS_CHAN_LO]     = chan;
			next_rdata[`POS_RANK_HI:`POS_RANK_LO]     = rank;
			next_rdata[`BIT_MIRR_PRI]                 = mirr_pri;
			next_rdata[`POS_OFS_HI_HI:`POS_OFS_HI_LO] = offset_hi;
		end
	end

	// read return register; data holds until the next read
	always @(posedge mclk) begin
		if (!rst_n) begin
			cfg_rdata <= `RST_WORD;
			cfg_rack  <= 1'b0;
		end else begin
			cfg_rack <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

	// ============================================================
	// spare copy tracker
	// the two status bits are read only, so writes never reach it
	spare_copy_tracker #(
		.RANK_W(RANK_W)
	) u_tracker (
		.mclk                        (mclk),
		.rst_n                       (rst_n),
		.spare_enable_new            (spare_enable_new),
		.spare_start                 (spare_start),
		.spare_finish                (spare_finish),
		.spare_fail                  (spare_fail),
		.dst_rank                    (dst_rank),
		.rank_interleave_target_we   (rank_interleave_target_we),
		.rank_interleave_target_rank (rank_interleave_target_rank),
		.request_home_release        (request_home_release),
		.spare_active                (spare_active),
		.spare_done                  (spare_done)
	);

endmodule

`default_nettype wire

// [rtl/spare_copy_tracker.v]
/*
 * spare-copy progress tracker: keeps the active and done flags and
 * sequences the rank interleave target update ahead of the release of
 * the request home block at the end of a copy.
 * assumes all inputs are single-cycle pulses on mclk from the copy
 * engine, which is on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module spare_copy_tracker #(
	parameter RANK_W = 3
) (
	// clock and reset
	input  wire              mclk,
	input  wire              rst_n,
	// copy engine events
	input  wire              spare_enable_new,
	input  wire              spare_start,
	input  wire              spare_finish,
	input  wire              spare_fail,
	input  wire [RANK_W-1:0] dst_rank,
	// target update and release
	output reg               rank_interleave_target_we,
	output reg  [RANK_W-1:0] rank_interleave_target_rank,
	output reg               request_home_release,
	// status flags
	output reg               spare_active,
	output reg               spare_done
);

	// ============================================================
	// state encoding, one-hot
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_COPY = 4'h2;
	localparam [3:0] ST_UPD  = 4'h4;
	localparam [3:0] ST_REL  = 4'h8;

	reg [3:0] state;       // current sequencer state
	reg [3:0] next_state;  // next sequencer state

	// next-state logic; a failure aborts without touching the target
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (spare_start) begin
					next_state = ST_COPY;
				end
			end
			ST_COPY: begin
				if (spare_fail) begin
					next_state = ST_IDLE;
				end else if (spare_finish) begin
					next_state = ST_UPD;
				end
			end
			ST_UPD: begin
				next_state = ST_REL;
			end
			ST_REL: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state register and flag updates
	always @(posedge mclk) begin
		if (!rst_n) begin
			state                       <= ST_IDLE;
			spare_active                <= 1'b0;
			spare_done                  <= 1'b0;
			rank_interleave_target_we   <= 1'b0;
			rank_interleave_target_rank <= {RANK_W{1'b0}};
			request_home_release        <= 1'b0;
		end else begin
			state <= next_state;
			// target written one cycle before the release pulse
			rank_interleave_target_we <= (state == ST_UPD);
			request_home_release      <= (state == ST_REL);
			if (state == ST_UPD) begin
				rank_interleave_target_rank <= dst_rank;
			end
			// active rises on start, falls on completion or failure
			if (state == ST_IDLE && spare_start) begin
				spare_active <= 1'b1;
			end else if (state == ST_REL ||
			             (state == ST_COPY && spare_fail)) begin
				spare_active <= 1'b0;
			end
			// done: completion set wins over the clear of a new enable
			if (state == ST_REL) begin
				spare_done <= 1'b1;
			end else if (spare_enable_new) begin
				spare_done <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// [tb/scrub_spare_status_regs_sva.sv]
/* port checker for the scrub and spare status register bank.
   assumes one clock mclk and a synchronous active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module scrub_spare_status_regs_sva (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// config read handshake
	input wire logic cfg_rd,
	input wire logic cfg_rack,
	// kick
	input wire logic scrub_kick_set,
	input wire logic scrub_issued,
	input wire logic scrub_kick,
	// spare copy end
	input wire logic spare_finish,
	input wire logic rank_interleave_target_we,
	input wire logic request_home_release
);
	// ======
	// timing frame
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// target update step, then home block release
	sequence s_upd;
		rank_interleave_target_we;
	endsequence
	sequence s_rel;
		request_home_release;
	endsequence
	// ======
	// assertions
	AST_RACK: assert property (cfg_rd |=> cfg_rack)
		else $error("read not answered next cycle");
	AST_RACK_CAUSE: assert property (cfg_rack |-> $past(cfg_rd))
		else $error("answer without a read");
	AST_KICK_SET: assert property (scrub_kick_set |=> scrub_kick)
		else $error("kick not raised");
	AST_KICK_CLR: assert property (
		scrub_kick && scrub_issued && !scrub_kick_set |=> !scrub_kick)
		else $error("kick not cleared after issue");
	AST_KICK_HOLD: assert property (
		scrub_kick && !scrub_issued |=> scrub_kick)
		else $error("kick dropped before issue");
	AST_FIN_FLOW: assert property (
		spare_finish |-> ##2 s_upd ##1 s_rel)
		else $error("target update and release out of step");
	AST_REL_AFTER_UPD: assert property (
		s_rel |-> $past(rank_interleave_target_we))
		else $error("release without preceding update");
	AST_UPD_CAUSE: assert property (
		s_upd |-> $past(spare_finish, 2))
		else $error("target update without finish");
endmodule
bind scrub_spare_status_regs scrub_spare_status_regs_sva
	scrub_spare_status_regs_sva_i (
	.mclk                     (mclk),
	.rst_n                    (rst_n),
	.cfg_rd                   (cfg_rd),
	.cfg_rack                 (cfg_rack),
	.scrub_kick_set           (scrub_kick_set),
	.scrub_issued             (scrub_issued),
	.scrub_kick               (scrub_kick),
	.spare_finish             (spare_finish),
	.rank_interleave_target_we(rank_interleave_target_we),
	.request_home_release     (request_home_release)
);
`default_nettype wire

// [tb/scrub_spare_status_regs_tb_top.sv]
/* self-checking bench: a register model is compared at every read.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module scrub_spare_status_regs_tb_top;
	// ======
	// stimulus, model and outputs
	logic        mclk, rst_n, cfg_wr, cfg_rd, sam, st;
	logic [11:0] cfg_addr;
	logic [31:0] cfg_wdata, m_lo, m_hi, m_st, d;
	logic [7:0]  evt;    // event pulses, one bit each
	logic [47:0] ia, fa; // issued and failing address
	logic [2:0]  dr, tgt, trk;
	logic [31:0] rdat, kro;
	logic [8:0]  kohi;
	logic [3:0]  krk;
	logic [1:0]  kch;
	logic        rack, kick, kmp, tw, rel;
	integer      n_errors, samples_checked, seed, i, k;
	scrub_spare_status_regs #(.RANK_W(3)) scrub_spare_status_regs_i (
		.mclk(mclk), .rst_n(rst_n), .cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
		.cfg_rdata(rdat), .cfg_rack(rack), .system_addr_mode(sam),
		.patrol_pass_end(evt[0]), .scrub_issued(evt[1]),
		.issued_rank_offset(ia[31:0]), .issued_chan(ia[33:32]),
		.issued_rank(ia[37:34]), .issued_mirr_pri(ia[38]),
		.issued_offset_hi(ia[47:39]), .selftest_active(st),
		.selftest_error(evt[2]), .fail_rank_offset(fa[31:0]),
		.fail_chan(fa[33:32]), .fail_rank(fa[37:34]),
		.fail_mirr_pri(fa[38]), .fail_offset_hi(fa[47:39]),
		.scrub_kick_set(evt[3]), .scrub_kick(kick),
		.kick_rank_offset(kro), .kick_chan(kch), .kick_rank(krk),
		.kick_mirr_pri(kmp), .kick_offset_hi(kohi),
		.spare_enable_new(evt[4]), .spare_start(evt[5]),
		.spare_finish(evt[6]), .spare_fail(evt[7]), .dst_rank(dr),
		.rank_interleave_target_we(tw),
		.rank_interleave_target_rank(trk), .request_home_release(rel));
	// ======
	// clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ======
	// helpers
	task tally_and_finish;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [47:0] got, input logic [47:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// high word layout of an address bundle
	function logic [31:0] hw(input logic [47:0] a);
		hw = {14'h0000, a[33:32], a[37:34], a[38], 2'h0, a[47:39]};
	endfunction
	// one-cycle pulse; model follows capture before issue
	task ev(input logic [7:0] m);
		@(negedge mclk) evt = m;
		@(negedge mclk) evt = 8'h00;
		if (m[2] && st) begin
			m_lo = fa[31:0];
			m_hi = hw(fa);
		end else if (m[1]) begin
			m_lo = ia[31:0];
			if (sam)
				m_hi = (m_hi & 32'h0003F000) | (hw(ia) & 32'h000009FF);
			else
				m_hi = (m_hi & 32'h00000800) | (hw(ia) & 32'h0003F1FF);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		@(negedge mclk);
		cfg_addr = a;
		cfg_wdata = v;
		cfg_wr = 1'b1;
		@(negedge mclk) cfg_wr = 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(negedge mclk);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge mclk) cfg_rd = 1'b0;
		for (k = 0; k < 4 && rack !== 1'b1; k++) @(negedge mclk);
		if (rack !== 1'b1) begin
			n_errors = n_errors + 1;
			tally_and_finish;
		end else begin
			chk(rdat, e);
		end
	endtask
	task rall;
		rd(12'h094, m_st);
		rd(12'h900, m_lo);
		rd(12'h910, m_hi);
	endtask
	// ======
	// main sequence
	initial begin
		seed = 32'hE6255CB1;
		{n_errors, samples_checked} = 64'h0;
		{rst_n, cfg_wr, cfg_rd, sam, st, evt, dr} = 16'h0000;
		{cfg_addr, cfg_wdata, ia, fa} = 140'h0;
		{m_st, m_lo, m_hi} = {64'h0, 32'h00000800};
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		rall;
		rd(12'h904, 32'h00000000);
		wr(12'h094, 32'hFFFFFFFF);
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			wr(12'h900, d);
			wr(12'h910, ~d);
			m_lo = d;
			m_hi = ~d & 32'h0003F9FF;
			rall;
		end
		// pass flag: set, ignore zero, clear on one
		ev(8'h01);
		m_st = 32'h4;
		rd(12'h094, m_st);
		wr(12'h094, 32'h0);
		rd(12'h094, m_st);
		wr(12'h094, 32'h4);
		m_st = 32'h0;
		rd(12'h094, m_st);
		// issue in both modes, then self-test capture against issue
		for (i = 0; i < 6; i++) begin
			sam = i[0];
			st = (i > 3);
			ia = {16'($random(seed)), 32'($random(seed))};
			fa = {16'($random(seed)), 32'($random(seed))};
			ev(i > 3 ? 8'h06 : 8'h02);
			rall;
		end
		st = 1'b0;
		ev(8'h04);
		rall;
		// kick takes the written address, drops on issue
		for (i = 0; i < 2; i++) begin
			sam = i[0];
			// model follows the written words, never the read data
			m_lo = $random(seed);
			wr(12'h900, m_lo);
			d = $random(seed);
			wr(12'h910, d);
			m_hi = d & 32'h0003F9FF;
			rd(12'h910, m_hi);
			rd(12'h900, m_lo);
			ev(8'h08);
			chk(kick, 48'h1);
			chk({kro, kch, krk, kmp, kohi}, {m_lo, sam ? 6'h00 : m_hi[17:12],
				sam ? m_hi[11] : 1'b0, m_hi[8:0]});
			ev(8'h02);
			chk(kick, 48'h0);
			rall;
		end
		// spare copy: start, finish, re-enable, fail
		dr = 3'($random(seed));
		tgt = ~dr;
		ev(8'h10);
		ev(8'h20);
		m_st = 32'h1;
		rd(12'h094, m_st);
		ev(8'h40);
		for (k = 0; k < 8 && rel !== 1'b1; k++) begin
			if (tw === 1'b1)
				tgt = trk;
			@(negedge mclk);
		end
		chk({rel, tgt}, {1'b1, dr});
		m_st = 32'h2;
		rd(12'h094, m_st);
		ev(8'h10);
		m_st = 32'h0;
		rd(12'h094, m_st);
		ev(8'h20);
		ev(8'h80);
		rd(12'h094, m_st);
		tally_and_finish;
	end
endmodule
`default_nettype wire
